// file: design/bdc_defines.svh
`ifndef BDC_DEFINES_SVH
`define BDC_DEFINES_SVH
// Register byte addresses
`define BDC_ADDR_CTRL 12'h000
`define BDC_ADDR_CMD 12'h004
`define BDC_ADDR_STAT 12'h008
// Control register fields
`define BDC_CTRL_BYPASS 0
`define BDC_CTRL_MSRC 1
`define BDC_CTRL_ERS_HI 4
`define BDC_CTRL_ERS_LO 2
`define BDC_CTRL_RATIO_HI 13
`define BDC_CTRL_RATIO_LO 8
`define BDC_CTRL_MAX_HI 24
`define BDC_CTRL_MAX_LO 16
`define BDC_CTRL_RESET 32'h01900a00
// Command register bits
`define BDC_CMD_START 0
`define BDC_CMD_EXIT 1
`define BDC_CMD_ERASE 2
// Delay ratio limits
`define BDC_RATIO_MIN 6'h0a
`define BDC_RATIO_MAX 6'h28
// Timing
`define BDC_TENTH_MS 100
`define BDC_CLK_KHZ 10000
`define BDC_BLINK_TENTHS 3'h4
`define BDC_ERASE_HOLD 5'h14
// Meter floor in dB below full scale
`define BDC_METER_FLOOR 6'h28
// Erase divisors
`define BDC_DIV_ERASE_ONE_A 9'h005
`define BDC_DIV_QUARTER 9'h004
`define BDC_DIV_THIRD 9'h003
`define BDC_DIV_HALF 9'h002
// Relay lamp colours
`define BDC_LAMP_OFF 2'h0
`define BDC_LAMP_GREEN 2'h1
`define BDC_LAMP_RED 2'h2
`endif

// file: design/bdc_pkg.sv
`default_nettype none
package bdc_pkg;
  typedef enum logic [2:0] {
    ZERO_DELAY_STATE = 3'h0,
    ADDING_DELAY = 3'h1,
    MAXIMUM_DELAY = 3'h3,
    REDUCING_DELAY = 3'h2,
    WAITING_RELEASE = 3'h6,
    MUTED_STATE = 3'h7
  } bdc_state_t;
  typedef enum logic [2:0] {
    ERASE_ONE_A = 3'h0,
    ERASE_QUARTER = 3'h1,
    ERASE_THIRD = 3'h2,
    ERASE_HALF = 3'h3,
    ERASE_ALL = 3'h4
  } bdc_erase_t;
  typedef struct packed {
    logic start;
    logic leave;
    logic cough;
    logic erase;
  } bdc_keys_t;
  typedef struct packed {
    logic bypassed;
    bdc_state_t state;
  } bdc_status_t;
  typedef struct packed {
    logic pass_through_readout;
    logic [8:0] tenths;
  } bdc_readout_t;
endpackage
`default_nettype wire

// file: design/bdc_top.sv
// Function
// - Pass-through relays tie analog inputs to outputs
// - Pass-through routes digital input to output
// - Pass-through ignores all keys; active obeys them
// - Pass-through shows bypassed status and readout letters
// - Active status shows one of six states
// - Readout shows stored delay in tenths
// - Two level bars, input or output source
// - Start ramps delay up to preset maximum
// - Start lamp blinks while delay increases, unless exit was given after the last start
// - Exit ramps delay down to zero
// - Exit lamp blinks while exit ramps delay down
// - Zero reached during exit shows removed state
// - Held mute plays memory, stops recording input
// - Mute release records, splices, rebuilds delay
// - Mute outlasting memory gives muted output
// - Erase discards configured fraction of memory
// - Erase splices around removed audio
// - Long erase hold empties memory, mutes output
// - Short erase press never mutes output
// - After erase resume previous build or release
// - Four relay lamps: dark, green, red
// - Delay ratio spans ten to forty
`timescale 1ns/100ps
`include "bdc_defines.svh"
`default_nettype none
module bdc_top import bdc_pkg::*; #(
  parameter int TENTH_CYCLES = `BDC_TENTH_MS * `BDC_CLK_KHZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operator keys
  input wire bdc_keys_t panel_keys,
  input wire bdc_keys_t remote_keys,
  // Level inputs, dB below full scale
  input wire logic [5:0] in_att_l,
  input wire logic [5:0] in_att_r,
  input wire logic [5:0] out_att_l,
  input wire logic [5:0] out_att_r,
  // Automation relay states
  input wire logic [3:0] relay_energized,
  input wire logic [3:0] relay_queued,
  // Audio path control
  output logic analog_bypass_q,
  output logic digital_bypass_q,
  output logic audio_mute_q,
  output logic record_en_q,
  output logic splice_q,
  // Display and lamps
  output bdc_status_t status_q,
  output bdc_readout_t readout_q,
  output logic [5:0] bar_l_q,
  output logic [5:0] bar_r_q,
  output logic start_lamp_q,
  output logic exit_lamp_q,
  output logic [7:0] automation_relay_lamps
);
  logic [31:0] ctrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  bdc_state_t state_q;
  bdc_state_t state_d;
  logic [8:0] delay_q;
  logic [8:0] delay_d;
  logic mode_q;
  logic mode_d;
  logic panic_q;
  logic panic_d;
  logic splice_d;
  bdc_keys_t keys_q;
  logic [19:0] tenth_cnt_q;
  logic [5:0] ratio_cnt_q;
  logic [4:0] hold_q;
  logic [2:0] blink_cnt_q;
  logic blink_q;
  logic [7:0] lamps_q;

  // APB decode
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire hit_ctrl = (paddr == `BDC_ADDR_CTRL);
  wire hit_cmd = (paddr == `BDC_ADDR_CMD);
  wire hit_stat = (paddr == `BDC_ADDR_STAT);
  wire hit_any = hit_ctrl | hit_cmd | hit_stat;
  wire wr_ok = access & pwrite & ~pslverr_q;
  wire wr_ctrl = wr_ok & hit_ctrl;
  wire wr_cmd = wr_ok & hit_cmd;
  wire [31:0] stat_word = {19'h00000, ctrl_q[`BDC_CTRL_BYPASS], state_q, delay_q};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_q : (hit_stat ? stat_word : 32'h00000000);

  // Control fields
  wire bypass = ctrl_q[`BDC_CTRL_BYPASS];
  wire meter_source_output = ctrl_q[`BDC_CTRL_MSRC];
  wire bdc_erase_t erase_sel = bdc_erase_t'(ctrl_q[`BDC_CTRL_ERS_HI:`BDC_CTRL_ERS_LO]);
  wire [5:0] ratio_raw = ctrl_q[`BDC_CTRL_RATIO_HI:`BDC_CTRL_RATIO_LO];
  wire [8:0] max_lim = ctrl_q[`BDC_CTRL_MAX_HI:`BDC_CTRL_MAX_LO];
  wire [5:0] ratio_lim = (ratio_raw < `BDC_RATIO_MIN) ? `BDC_RATIO_MIN :
                         (ratio_raw > `BDC_RATIO_MAX) ? `BDC_RATIO_MAX : ratio_raw;

  // Command decode, dead in pass-through
  wire bdc_keys_t keys = bdc_keys_t'(panel_keys | remote_keys);
  wire start_p = ~bypass & ((keys.start & ~keys_q.start) |
                 (wr_cmd & pwdata[`BDC_CMD_START]));
  wire exit_p = ~bypass & ((keys.leave & ~keys_q.leave) |
                (wr_cmd & pwdata[`BDC_CMD_EXIT]));
  wire erase_p = ~bypass & ((keys.erase & ~keys_q.erase) |
                 (wr_cmd & pwdata[`BDC_CMD_ERASE]));
  wire mute_p = ~bypass & keys.cough & ~keys_q.cough;
  wire mute_held = keys.cough;
  wire erase_held = keys.erase;
  wire any_cmd = start_p | exit_p | erase_p | mute_p;

  // Time base
  wire tick = (tenth_cnt_q == 20'(TENTH_CYCLES - 1));
  wire step = tick & (ratio_cnt_q == (ratio_lim - 6'h01));
  wire panic = ~bypass & erase_held & tick & (hold_q == (`BDC_ERASE_HOLD - 5'h01));

  // Erase portion
  wire [8:0] portion = (erase_sel == ERASE_ONE_A) ? delay_q / `BDC_DIV_ERASE_ONE_A :
                       (erase_sel == ERASE_QUARTER) ? delay_q / `BDC_DIV_QUARTER :
                       (erase_sel == ERASE_THIRD) ? delay_q / `BDC_DIV_THIRD :
                       (erase_sel == ERASE_HALF) ? delay_q / `BDC_DIV_HALF : delay_q;
  wire [8:0] erased = delay_q - portion;

  function automatic bdc_state_t resume(input logic rel, input logic [8:0] d,
                                        input logic [8:0] mx);
    if (rel) begin
      resume = (d == 9'h000) ? ZERO_DELAY_STATE : REDUCING_DELAY;
    end else begin
      resume = (d >= mx) ? MAXIMUM_DELAY : ADDING_DELAY;
    end
  endfunction

  // Delay state machine
  always_comb begin
    state_d = state_q;
    delay_d = delay_q;
    mode_d = mode_q;
    panic_d = panic_q;
    splice_d = 1'b0;
    case (state_q)
      ADDING_DELAY: begin
        if (step) begin
          if (delay_q >= max_lim - 9'h001) begin
            delay_d = max_lim;
            state_d = MAXIMUM_DELAY;
          end else begin
            delay_d = delay_q + 9'h001;
          end
        end
      end
      REDUCING_DELAY: begin
        if (step) begin
          if (delay_q <= 9'h001) begin
            delay_d = 9'h000;
            state_d = ZERO_DELAY_STATE;
          end else begin
            delay_d = delay_q - 9'h001;
          end
        end
      end
      WAITING_RELEASE: begin
        if (!mute_held) begin
          splice_d = 1'b1;
          state_d = ADDING_DELAY;
        end else if (tick) begin
          if (delay_q == 9'h000) begin
            state_d = MUTED_STATE;
          end else begin
            delay_d = delay_q - 9'h001;
          end
        end
      end
      MUTED_STATE: begin
        if (panic_q && !erase_held) begin
          panic_d = 1'b0;
          splice_d = 1'b1;
          state_d = resume(mode_q, delay_q, max_lim);
        end else if (!panic_q && !mute_held) begin
          splice_d = 1'b1;
          state_d = ADDING_DELAY;
        end
      end
      default: begin
        state_d = state_q;
      end
    endcase
    if (start_p) begin
      mode_d = 1'b0;
      state_d = resume(1'b0, delay_q, max_lim);
    end
    if (exit_p) begin
      mode_d = 1'b1;
      state_d = resume(1'b1, delay_q, max_lim);
    end
    if (mute_p) begin
      panic_d = 1'b0;
      state_d = WAITING_RELEASE;
    end
    if (erase_p) begin
      panic_d = 1'b0;
      delay_d = erased;
      splice_d = 1'b1;
      state_d = resume(mode_q, erased, max_lim);
    end
    if (panic) begin
      panic_d = 1'b1;
      delay_d = 9'h000;
      state_d = MUTED_STATE;
    end
  end

  // APB registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `BDC_CTRL_RESET;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
      if (wr_ctrl) begin
        ctrl_q <= pwdata;
      end
    end
  end

  // Time base counters
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tenth_cnt_q <= 20'h00000;
      ratio_cnt_q <= 6'h00;
      hold_q <= 5'h00;
      blink_cnt_q <= 3'h0;
      blink_q <= 1'b0;
    end else if (ce) begin
      tenth_cnt_q <= tick ? 20'h00000 : tenth_cnt_q + 20'h00001;
      if (any_cmd || step) begin
        ratio_cnt_q <= 6'h00;
      end else if (tick) begin
        ratio_cnt_q <= ratio_cnt_q + 6'h01;
      end
      if (!erase_held || erase_p) begin
        hold_q <= 5'h00;
      end else if (tick && hold_q != `BDC_ERASE_HOLD) begin
        hold_q <= hold_q + 5'h01;
      end
      if (tick) begin
        blink_cnt_q <= (blink_cnt_q == `BDC_BLINK_TENTHS) ? 3'h0 : blink_cnt_q + 3'h1;
        blink_q <= (blink_cnt_q == `BDC_BLINK_TENTHS) ? ~blink_q : blink_q;
      end
    end
  end

  // State registers, frozen in pass-through
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ZERO_DELAY_STATE;
      delay_q <= 9'h000;
      mode_q <= 1'b0;
      panic_q <= 1'b0;
      keys_q <= '0;
    end else if (ce) begin
      keys_q <= keys;
      if (!bypass) begin
        state_q <= state_d;
        delay_q <= delay_d;
        mode_q <= mode_d;
        panic_q <= panic_d;
      end
    end
  end

  // Relay lamp colours
  generate
    for (genvar i = 0; i < 4; i++) begin : g_lamp
      logic [1:0] lamp_q;
      wire [1:0] colour = relay_energized[i] ? `BDC_LAMP_GREEN :
                          relay_queued[i] ? `BDC_LAMP_RED : `BDC_LAMP_OFF;
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          lamp_q <= `BDC_LAMP_OFF;
        end else if (ce) begin
          lamp_q <= colour;
        end
      end
      assign lamps_q[2*i+1:2*i] = lamp_q;
    end
  endgenerate

  // Meter bars
  wire [5:0] att_l = meter_source_output ? out_att_l : in_att_l;
  wire [5:0] att_r = meter_source_output ? out_att_r : in_att_r;
  wire [5:0] bar_l_d = (att_l >= `BDC_METER_FLOOR) ? 6'h00 : `BDC_METER_FLOOR - att_l;
  wire [5:0] bar_r_d = (att_r >= `BDC_METER_FLOOR) ? 6'h00 : `BDC_METER_FLOOR - att_r;
  wire bdc_state_t shown = bypass ? state_q : state_d;
  wire hush = (shown == WAITING_RELEASE) | (shown == MUTED_STATE);

  // Output registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      analog_bypass_q <= 1'b0;
      digital_bypass_q <= 1'b0;
      audio_mute_q <= 1'b0;
      record_en_q <= 1'b1;
      splice_q <= 1'b0;
      status_q <= '0;
      readout_q <= '0;
      bar_l_q <= 6'h00;
      bar_r_q <= 6'h00;
      start_lamp_q <= 1'b0;
      exit_lamp_q <= 1'b0;
    end else if (ce) begin
      analog_bypass_q <= bypass;
      digital_bypass_q <= bypass;
      audio_mute_q <= ~bypass & (shown == MUTED_STATE);
      record_en_q <= ~bypass & ~hush;
      splice_q <= ~bypass & splice_d;
      status_q <= '{bypassed: bypass, state: shown};
      readout_q <= '{pass_through_readout: bypass,
                     tenths: bypass ? 9'h000 : delay_d};
      bar_l_q <= bar_l_d;
      bar_r_q <= bar_r_d;
      start_lamp_q <= ~bypass & (shown == ADDING_DELAY) & ~mode_d & blink_q;
      exit_lamp_q <= ~bypass & (shown == REDUCING_DELAY) & blink_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign automation_relay_lamps = lamps_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_analog_bypass: assert property (ce |=> analog_bypass_q == $past(bypass))
    else $error("analog bypass relay not following control");
  a_digital_bypass: assert property (digital_bypass_q == analog_bypass_q)
    else $error("digital bypass differs from analog bypass");
  a_bypass_frozen: assert property (ce && bypass |=> $stable(state_q) && $stable(delay_q))
    else $error("state moved in pass-through");
  a_bypass_readout: assert property (analog_bypass_q |->
      readout_q.pass_through_readout && status_q.bypassed)
    else $error("pass-through not shown on displays");
  a_delay_readout: assert property (!status_q.bypassed |-> readout_q.tenths == delay_q)
    else $error("readout differs from stored delay");
  a_ramp_up: assert property (ce && !bypass && state_q == ADDING_DELAY && step && !any_cmd
      && !panic && delay_q + 9'h001 < max_lim |=> delay_q == $past(delay_q) + 9'h001)
    else $error("delay did not grow by one step");
  a_exit_zero: assert property (ce && !bypass && state_q == REDUCING_DELAY && step
      && !any_cmd && !panic && delay_q == 9'h001 |=> state_q == ZERO_DELAY_STATE)
    else $error("exit did not end in zero delay state");
  a_cough_record: assert property (state_q == WAITING_RELEASE && !analog_bypass_q
      |-> !record_en_q)
    else $error("recording while mute held");
  a_erase_all: assert property (ce && erase_p && erase_sel == ERASE_ALL && !panic
      |=> delay_q == 9'h000 ##0 splice_q)
    else $error("erase all left audio or no splice");
  a_start_lamp: assert property (start_lamp_q |-> status_q.state == ADDING_DELAY)
    else $error("start lamp lit without increasing delay");

  c_reach_max: cover property (state_q == ADDING_DELAY ##1 state_q == MAXIMUM_DELAY);
  c_reach_zero: cover property (state_q == REDUCING_DELAY ##1 state_q == ZERO_DELAY_STATE);
  c_cough_release: cover property (state_q == WAITING_RELEASE ##1 state_q == ADDING_DELAY);
  c_panic_mute: cover property (panic_q && audio_mute_q);
endmodule
`default_nettype wire

// file: verification/bdc_key_model.sv
`timescale 1ns/100ps
`default_nettype none
module bdc_key_model import bdc_pkg::*; (
  // Clock
  input wire logic core_clk,
  // Keys toward the block
  output bdc_keys_t keys
);
  initial keys = '0;
  // Keys are held levels; a press is the rise
  task automatic set(input int idx, input logic v);
    @(posedge core_clk);
    keys[idx] <= v;
  endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import bdc_pkg::*;
  logic core_clk, resetn, ce, psel, penable, pwrite, pready, pslverr, sp, am;
  logic ab, db, am_q, rec, spl, sl, el, sl1, sl0, el1, el0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] att_il, att_ir, att_ol, att_or, bl, br;
  logic [3:0] ren, rq;
  logic [7:0] lamps;
  bdc_keys_t pk, rk;
  bdc_status_t st;
  bdc_readout_t ro;
  int errors = 0;
  int check_count = 0;
  bdc_key_model key (.core_clk(core_clk), .keys(pk));
  bdc_top #(.TENTH_CYCLES(4)) dut (.core_clk(core_clk), .resetn(resetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .panel_keys(pk),
    .remote_keys(rk), .in_att_l(att_il), .in_att_r(att_ir), .out_att_l(att_ol),
    .out_att_r(att_or), .relay_energized(ren), .relay_queued(rq),
    .analog_bypass_q(ab), .digital_bypass_q(db), .audio_mute_q(am_q),
    .record_en_q(rec), .splice_q(spl), .status_q(st), .readout_q(ro), .bar_l_q(bl),
    .bar_r_q(br), .start_lamp_q(sl), .exit_lamp_q(el), .automation_relay_lamps(lamps));
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    rd = prdata;
    sp = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Waits for a state, noting splice, mute and lamp activity meanwhile
  task automatic wst(input bdc_state_t s, input int lim);
    int n;
    n = 0;
    {sp, am, sl1, sl0, el1, el0} = '0;
    do begin
      @(negedge core_clk);
      n++;
      sp |= spl;
      am |= am_q;
      sl1 |= sl;
      sl0 |= !sl;
      el1 |= el;
      el0 |= !el;
    end while (st.state !== s && n < lim);
    if (st.state !== s) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic t_regs();
    apb(0, 12'h000, 0);
    chk(rd, 32'h01900a00);
    chk({sp, rec, st, ro}, {2'b01, 4'h0, 10'h000});
    apb(0, 12'hffc, 0);
    chk(sp, 1);
    $display("regs done");
  endtask
  task automatic t_meters();
    {att_il, att_ir, att_ol, att_or} <= {6'h00, 6'h06, 6'h32, 6'h0a};
    {ren, rq} <= 8'h36;
    repeat (3) @(posedge core_clk);
    chk({bl, br, lamps}, {6'h28, 6'h22, 8'h25});
    apb(1, 12'h000, 32'h00030a0e);
    repeat (2) @(posedge core_clk);
    chk({bl, br}, {6'h00, 6'h1e});
    ce <= 1'b0;
    {att_ol, att_or} <= {6'h00, 6'h00};
    repeat (3) @(posedge core_clk);
    chk({bl, br}, {6'h00, 6'h1e});
    ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({bl, br}, {6'h28, 6'h28});
    $display("meters done");
  endtask
  task automatic t_start();
    key.set(3, 1);
    key.set(3, 0);
    wst(ADDING_DELAY, 5);
    wst(MAXIMUM_DELAY, 400);
    chk({sl1, sl0, ro}, {2'b11, 10'h003});
    apb(0, 12'h008, 0);
    chk(rd, 32'h00000603);
    $display("start done");
  endtask
  task automatic t_erase();
    key.set(0, 1);
    key.set(0, 0);
    wst(ADDING_DELAY, 5);
    chk({ro.tenths, sp}, {9'h002, 1'b1});
    wst(MAXIMUM_DELAY, 60);
    chk(am, 0);
    key.set(0, 1);
    wst(MUTED_STATE, 100);
    chk({am_q, ro.tenths}, {1'b1, 9'h000});
    key.set(0, 0);
    wst(ADDING_DELAY, 5);
    chk({sp, am_q}, 2'b10);
    $display("erase done");
  endtask
  task automatic t_cough();
    wst(MAXIMUM_DELAY, 400);
    key.set(1, 1);
    wst(WAITING_RELEASE, 5);
    chk({rec, am_q}, 2'b00);
    wst(MUTED_STATE, 40);
    chk({am_q, ro.tenths}, {1'b1, 9'h000});
    key.set(1, 0);
    wst(ADDING_DELAY, 5);
    chk({sp, rec, am_q}, 3'b110);
    $display("cough done");
  endtask
  task automatic t_exit();
    wst(MAXIMUM_DELAY, 400);
    apb(1, 12'h000, 32'h00030a10);
    apb(1, 12'h004, 32'h00000004);
    wst(ADDING_DELAY, 5);
    chk({ro.tenths, sp}, {9'h000, 1'b1});
    wst(MAXIMUM_DELAY, 400);
    @(posedge core_clk);
    rk.leave <= 1;
    @(posedge core_clk);
    rk.leave <= 0;
    wst(REDUCING_DELAY, 5);
    wst(ZERO_DELAY_STATE, 600);
    chk({el1, el0, ro}, {2'b11, 10'h000});
    $display("exit done");
  endtask
  task automatic t_bypass();
    apb(1, 12'h000, 32'h00030a0d);
    key.set(3, 1);
    repeat (60) @(posedge core_clk);
    chk({ab, db, st, ro}, {3'b111, ZERO_DELAY_STATE, 10'h200});
    key.set(3, 0);
    apb(1, 12'h000, 32'h00030a0c);
    repeat (60) @(posedge core_clk);
    chk({ab, db, st}, {2'b00, 1'b0, ZERO_DELAY_STATE});
    $display("bypass done");
  endtask
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {att_il, att_ir, att_ol, att_or, ren, rq, rk} = '0;
    ce = 1'b1;
    repeat (3) @(posedge core_clk);
    resetn <= 1;
    t_regs();
    t_meters();
    t_start();
    t_erase();
    t_cough();
    t_exit();
    t_bypass();
    tally_and_finish();
  end
endmodule
`default_nettype wire
